// ---- shared/ebi_pkg.sv ----
package ebi_pkg;

    // one clk is half a system clock; the bus cycle phases step on it
    localparam int CLK_PERIOD_NS      = 100;
    localparam int SYS_CLOCK_NS       = 200;
    localparam int HALF_CLOCK_NS      = SYS_CLOCK_NS / 2;
    localparam int HALF_CLOCK_CYCLES  =
        (HALF_CLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FULL_CLOCK_CYCLES  =
        (SYS_CLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HALF_RELOAD = 4'(HALF_CLOCK_CYCLES - 1);
    localparam logic [3:0] WDATA_RELOAD =
        4'(FULL_CLOCK_CYCLES - HALF_CLOCK_CYCLES - 1);

    // byte count codes
    localparam logic [1:0] COUNT_ONE   = 2'h1;
    localparam logic [1:0] COUNT_TWO   = 2'h2;
    localparam logic [1:0] COUNT_THREE = 2'h3;
    localparam logic [1:0] COUNT_FOUR  = 2'h0;

    // space codes
    localparam logic [2:0] SPACE_RESERVED = 3'h4;
    localparam logic [2:0] SPACE_DATA     = 3'h5;
    localparam logic [2:0] SPACE_PROGRAM  = 3'h6;
    localparam logic [2:0] SPACE_CONTROL  = 3'h7;

    // size acknowledge pin levels, high line first
    localparam logic [1:0] ACK_WAIT     = 2'h3;
    localparam logic [1:0] ACK_PORT8    = 2'h2;
    localparam logic [1:0] ACK_PORT16   = 2'h1;
    localparam logic [1:0] ACK_RESERVED = 2'h0;

    localparam logic [23:0] ADDR_RESET  = 24'h000000;
    localparam logic [2:0]  SPACE_RESET = SPACE_DATA;

    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_STROBE,
        S_WDATA,
        S_WSTROBE,
        S_WAIT
    } state_e;

    // bytes moved by one cycle
    function automatic logic [2:0] bytes_moved(
        input logic       port16,
        input logic       addr0,
        input logic [2:0] remain
    );
        bytes_moved = (port16 && !addr0 && remain >= 3'h2) ? 3'h2 : 3'h1;
    endfunction

    // code 00 stands for four bytes
    function automatic logic [2:0] count_of(input logic [1:0] code);
        count_of = (code == COUNT_FOUR) ? 3'h4 : {1'b0, code};
    endfunction

endpackage

// ---- design/lane_mux.sv ----
`timescale 1ns/1ns
module lane_mux
(
    input  wire logic [15:0] oper_top,
    input  wire logic        addr0,
    input  wire logic [2:0]  remain,
    input  wire logic        port16,
    input  wire logic [15:0] bus_in,
    output logic      [15:0] bus_out,
    output logic      [7:0]  rd_byte
);

    ////////////////////////////////////////////////////////////////////////
    // an aligned pair goes out as is; a lone byte is copied to both
    // lanes so a 16-bit port at an odd address sees it on the low lane
    always_comb
    begin
        if (!addr0 && remain >= 3'h2)
            bus_out = oper_top;
        else
            bus_out = {oper_top[15:8], oper_top[15:8]};
    end

    // odd bytes of a 16-bit port arrive on the low lane only
    always_comb
    begin
        if (port16 && addr0)
            rd_byte = bus_in[7:0];
        else
            rd_byte = bus_in[15:8];
    end

endmodule

// ---- design/term_decoder.sv ----
`timescale 1ns/1ns
module term_decoder
(
    input  wire logic port_ack_high_n,
    input  wire logic port_ack_low_n,
    input  wire logic bus_error_n,
    input  wire logic halt_n,
    input  wire logic autovector_n,
    input  wire logic iack_cycle,
    output logic      term_valid,
    output logic      term_port16,
    output logic      term_error,
    output logic      term_autovector_input
);

    logic [1:0] ack;

    assign ack = {port_ack_high_n, port_ack_low_n};

    ////////////////////////////////////////////////////////////////////////
    // halt does not soften a bus error: both low still means exception
    always_comb
    begin
        term_error  = !bus_error_n;
        term_autovector_input   = !term_error && iack_cycle && !autovector_n;
        term_port16 = (ack == ebi_pkg::ACK_PORT16);
        term_valid  = term_error || term_autovector_input
                      || ack == ebi_pkg::ACK_PORT8
                      || ack == ebi_pkg::ACK_PORT16;
        if (!halt_n && !term_error)
            term_valid = term_valid;
    end

endmodule

// ---- design/ebi_master.sv ----
`timescale 1ns/1ns
module ebi_master
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_iack,
    input  wire logic [19:0] req_addr,
    input  wire logic [1:0]  req_count,
    input  wire logic [1:0]  req_space,
    input  wire logic [31:0] req_wdata,
    output logic             req_ready,
    output logic             done,
    output logic [31:0]      rd_data,
    output logic             bus_error_seen,
    output logic             autovector_seen,
    output logic [23:0]      addr,
    output logic             byte_count_code_high,
    output logic             byte_count_code_low,
    output logic [2:0]       space_code,
    output logic             read_write,
    output logic             location_strobe_n,
    output logic             payload_strobe_n,
    input  wire logic [15:0] data_in,
    output logic [15:0]      data_out,
    output logic             data_oe,
    input  wire logic        port_ack_high_n,
    input  wire logic        port_ack_low_n,
    input  wire logic        bus_error_n,
    input  wire logic        halt_n,
    input  wire logic        autovector_n
);

    ebi_pkg::state_e state_q;
    ebi_pkg::state_e state_d;
    logic [3:0]  tick_q;
    logic [2:0]  rem_q;
    logic [19:0] addr_q;
    logic [31:0] oper_q;
    logic [31:0] acc_q;
    logic        write_q;
    logic        iack_q;
    logic        step;
    logic        term_valid;
    logic        term_port16;
    logic        term_error;
    logic        term_autovector_input;
    logic        term_take;
    logic        finish;
    logic [2:0]  moved;
    logic [2:0]  rem_after;
    logic [19:0] nxt_addr;
    logic [2:0]  nxt_rem;
    logic [15:0] placed;
    logic [7:0]  rd_byte;

    ////////////////////////////////////////////////////////////////////////
    // acks are only looked at once both strobes are down
    term_decoder u_term
    (
        .port_ack_high_n (port_ack_high_n),
        .port_ack_low_n  (port_ack_low_n),
        .bus_error_n     (bus_error_n),
        .halt_n          (halt_n),
        .autovector_n    (autovector_n),
        .iack_cycle      (iack_q && space_code == ebi_pkg::SPACE_CONTROL),
        .term_valid      (term_valid),
        .term_port16     (term_port16),
        .term_error      (term_error),
        .term_autovector_input       (term_autovector_input)
    );

    lane_mux u_lanes
    (
        .oper_top (oper_q[31:16]),
        .addr0    (addr_q[0]),
        .remain   (rem_q),
        .port16   (term_port16),
        .bus_in   (data_in),
        .bus_out  (placed),
        .rd_byte  (rd_byte)
    );

    assign step      = (tick_q == 4'h0);
    assign term_take = (state_q == ebi_pkg::S_WAIT) && term_valid;
    assign moved     = ebi_pkg::bytes_moved(term_port16, addr_q[0], rem_q);
    assign rem_after = rem_q - moved;
    assign finish    = term_take
                       && (term_error || term_autovector_input || rem_after == 3'h0);

    // values for the next cycle of the operand, or for a fresh one
    always_comb
    begin
        if (state_q == ebi_pkg::S_IDLE)
        begin
            nxt_addr = req_addr;
            nxt_rem  = ebi_pkg::count_of(req_count);
        end
        else
        begin
            nxt_addr = addr_q + {17'h0, moved};
            nxt_rem  = rem_after;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ebi_pkg::S_IDLE:
                if (req_valid)
                    state_d = ebi_pkg::S_START;
            ebi_pkg::S_START:
                if (step)
                    state_d = ebi_pkg::S_STROBE;
            ebi_pkg::S_STROBE:
                if (step)
                    state_d = write_q ? ebi_pkg::S_WDATA
                                      : ebi_pkg::S_WAIT;
            ebi_pkg::S_WDATA:
                if (step)
                    state_d = ebi_pkg::S_WSTROBE;
            ebi_pkg::S_WSTROBE:
                state_d = ebi_pkg::S_WAIT;
            ebi_pkg::S_WAIT:
                if (finish)
                    state_d = ebi_pkg::S_IDLE;
                else if (term_take)
                    state_d = ebi_pkg::S_START;
            default:
                state_d = ebi_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            state_q <= ebi_pkg::S_IDLE;
        else
            state_q <= state_d;
    end

    // dwell timer: each phase lasts half a system clock
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            tick_q <= 4'h0;
        else if (state_d != state_q)
            tick_q <= (state_d == ebi_pkg::S_WDATA) ? ebi_pkg::WDATA_RELOAD
                                                     : ebi_pkg::HALF_RELOAD;
        else if (tick_q != 4'h0)
            tick_q <= tick_q - 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // operand bookkeeping; byte zero is kept in the top byte
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            addr_q  <= 20'h00000;
            rem_q   <= 3'h0;
            oper_q  <= 32'h00000000;
            write_q <= 1'b0;
            iack_q  <= 1'b0;
        end
        else if (state_q == ebi_pkg::S_IDLE && req_valid)
        begin
            addr_q  <= nxt_addr;
            rem_q   <= nxt_rem;
            write_q <= req_write;
            iack_q  <= req_iack;
            case (nxt_rem)
                3'h1:    oper_q <= {req_wdata[7:0], 24'h000000};
                3'h2:    oper_q <= {req_wdata[15:0], 16'h0000};
                3'h3:    oper_q <= {req_wdata[23:0], 8'h00};
                default: oper_q <= req_wdata;
            endcase
        end
        else if (term_take && !finish)
        begin
            addr_q <= nxt_addr;
            rem_q  <= nxt_rem;
            if (moved == 3'h2)
                oper_q <= {oper_q[15:0], 16'h0000};
            else
                oper_q <= {oper_q[23:0], 8'h00};
        end
    end

    // read accumulation: later bytes shift in below earlier ones
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            acc_q <= 32'h00000000;
        else if (state_q == ebi_pkg::S_IDLE && req_valid)
            acc_q <= 32'h00000000;
        else if (term_take && !write_q && !term_error && !term_autovector_input)
        begin
            if (moved == 3'h2)
                acc_q <= {acc_q[15:0], data_in};
            else
                acc_q <= {acc_q[23:0], rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address, count, space and direction change only on a cycle start
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            addr                 <= ebi_pkg::ADDR_RESET;
            byte_count_code_high <= 1'b0;
            byte_count_code_low  <= 1'b0;
            space_code           <= ebi_pkg::SPACE_RESET;
            read_write           <= 1'b1;
        end
        else if (state_d == ebi_pkg::S_START)
        begin
            addr <= {{4{nxt_addr[19]}}, nxt_addr};
            {byte_count_code_high, byte_count_code_low} <= nxt_rem[1:0];
            if (state_q == ebi_pkg::S_IDLE)
            begin
                space_code <= {1'b1, req_space};
                read_write <= !req_write;
            end
        end
    end

    // strobes: reads drop both together, writes a full clock apart
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            location_strobe_n <= 1'b1;
            payload_strobe_n  <= 1'b1;
        end
        else
        begin
            location_strobe_n <= !(state_d == ebi_pkg::S_STROBE
                                   || state_d == ebi_pkg::S_WDATA
                                   || state_d == ebi_pkg::S_WSTROBE
                                   || state_d == ebi_pkg::S_WAIT);
            payload_strobe_n  <= !((state_d == ebi_pkg::S_STROBE
                                    && !write_q)
                                   || state_d == ebi_pkg::S_WSTROBE
                                   || state_d == ebi_pkg::S_WAIT);
        end
    end

    // write data; all lanes driven so an unused lane never floats
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            data_out <= 16'h0000;
            data_oe  <= 1'b0;
        end
        else
        begin
            data_oe <= write_q && (state_d == ebi_pkg::S_WDATA
                                   || state_d == ebi_pkg::S_WSTROBE
                                   || state_d == ebi_pkg::S_WAIT);
            if (state_d == ebi_pkg::S_WDATA)
                data_out <= placed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // results to the requester
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            req_ready       <= 1'b1;
            done            <= 1'b0;
            rd_data         <= 32'h00000000;
            bus_error_seen  <= 1'b0;
            autovector_seen <= 1'b0;
        end
        else
        begin
            req_ready <= (state_d == ebi_pkg::S_IDLE);
            done      <= finish;
            if (finish)
            begin
                bus_error_seen  <= term_error;
                autovector_seen <= term_autovector_input;
                if (!write_q && !term_error && !term_autovector_input)
                begin
                    if (moved == 3'h2)
                        rd_data <= {acc_q[15:0], data_in};
                    else
                        rd_data <= {acc_q[23:0], rd_byte};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence as_fall;
        $fell(location_strobe_n);
    endsequence

    sequence write_steps;
        data_oe && payload_strobe_n ##1 $fell(payload_strobe_n);
    endsequence

    a_as_half_clock: assert property (
        as_fall |-> $past(state_q) == ebi_pkg::S_START)
        else $error("location strobe not half a clock after start");

    a_read_strobes: assert property (
        as_fall and read_write |-> $fell(payload_strobe_n))
        else $error("read payload strobe not with location strobe");

    a_write_strobes: assert property (
        as_fall and !read_write |-> payload_strobe_n ##1 write_steps)
        else $error("write data or payload strobe mistimed");

    a_dir_stable: assert property (
        !location_strobe_n |-> $stable(read_write))
        else $error("direction changed inside a cycle");

    a_space_top: assert property (
        !location_strobe_n |-> space_code[2])
        else $error("space code top bit clear");

    a_addr_copy: assert property (
        addr[23:20] == {4{addr[19]}})
        else $error("upper address lines do not copy bit 19");

    a_count_stable: assert property (
        !location_strobe_n |-> $stable({addr, byte_count_code_high,
                                        byte_count_code_low}))
        else $error("address or byte count moved under strobe");

    a_write_lanes: assert property (
        !payload_strobe_n && !read_write |-> data_oe)
        else $error("write without data lines driven");

    a_error_ends: assert property (
        state_q == ebi_pkg::S_WAIT && !bus_error_n
        |=> done && bus_error_seen && location_strobe_n)
        else $error("bus error did not end the operand");

    a_long_16bit: assert property (
        state_q == ebi_pkg::S_WAIT && term_port16 && !term_error
        && !term_autovector_input && rem_q == 3'h4 && !addr_q[0]
        |=> !done ##1 {byte_count_code_high, byte_count_code_low}
            == ebi_pkg::COUNT_TWO)
        else $error("second cycle of long word missing");

endmodule

// ---- tb/far_memory.sv ----
`timescale 1ns/1ns
module far_memory
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [23:0] addr,
    input  wire logic        byte_count_code_high,
    input  wire logic        byte_count_code_low,
    input  wire logic        location_strobe_n,
    input  wire logic        payload_strobe_n,
    input  wire logic        read_write,
    input  wire logic [15:0] data_out,
    input  wire logic        port8,
    input  wire logic [3:0]  waits,
    input  wire logic        no_ack,
    input  wire logic        err,
    input  wire logic        halt,
    input  wire logic        autovector_input,
    output logic      [15:0] data_in,
    output logic             port_ack_high_n,
    output logic             port_ack_low_n,
    output logic             bus_error_n,
    output logic             halt_n,
    output logic             autovector_n
);
    logic [7:0] mem [0:255];
    logic [3:0] wait_q;
    logic       ended_q;
    logic [7:0] a;

    assign a = addr[7:0];
    // held low when asked, so every cycle sees it
    assign autovector_n = ~autovector_input;

    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            port_ack_high_n <= 1'b1;
            port_ack_low_n  <= 1'b1;
            bus_error_n     <= 1'b1;
            halt_n          <= 1'b1;
            wait_q          <= 4'h0;
            ended_q         <= 1'b0;
            data_in         <= 16'h0000;
        end
        else if (location_strobe_n)
        begin
            // released data lines toggle so a stale value never passes
            port_ack_high_n <= 1'b1;
            port_ack_low_n  <= 1'b1;
            bus_error_n     <= 1'b1;
            halt_n          <= 1'b1;
            wait_q          <= 4'h0;
            ended_q         <= 1'b0;
            data_in         <= ~data_in;
        end
        else if (!payload_strobe_n && !ended_q)
        begin
            if (wait_q != waits)
            begin
                wait_q  <= wait_q + 4'h1; // wait states before the ack
                data_in <= ~data_in;
            end
            else
            begin
                ended_q <= 1'b1;
                if (err)
                begin
                    bus_error_n <= 1'b0;
                    halt_n      <= ~halt;
                end
                if (!no_ack)
                begin
                    port_ack_high_n <= port8;
                    port_ack_low_n  <= ~port8;
                end
                if (port8)
                    data_in <= {mem[a], ~mem[a]};
                else
                    data_in <= {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};
                if (!read_write && !no_ack)
                begin
                    mem[a] <= (port8 || !a[0]) ? data_out[15:8]
                                               : data_out[7:0];
                    if (!port8 && !a[0] &&
                        {byte_count_code_high, byte_count_code_low} != 2'h1)
                        mem[a + 8'h1] <= data_out[7:0];
                end
            end
        end
    end
endmodule

// ---- tb/ebi_master_tb.sv ----
`timescale 1ns/1ns
module ebi_master_tb;
    logic        clk, reset, req_valid, req_write, req_iack, req_ready;
    logic [19:0] req_addr;
    logic [1:0]  req_count, req_space, lc, fc;
    logic [31:0] req_wdata, rd_data;
    logic        done, bus_error_seen, autovector_seen, read_write;
    logic [23:0] addr, fa, la;
    logic        byte_count_code_high, byte_count_code_low, data_oe;
    logic [2:0]  space_code, fs;
    logic        location_strobe_n, payload_strobe_n, halt_n, autovector_n;
    logic [15:0] data_in, data_out, wdat;
    logic        port_ack_high_n, port_ack_low_n, bus_error_n;
    logic        port8, no_ack, err, halt, autovector_input, loc_p, pay_p, oe_p, rw_p;
    logic [3:0]  waits;
    int          num_errors, num_checks, ncyc, pgap, dgap, flips, tcnt, lt;

    ebi_master u_ebi_master (.clk(clk), .reset(reset),
        .req_valid(req_valid), .req_write(req_write), .req_iack(req_iack),
        .req_addr(req_addr), .req_count(req_count), .req_space(req_space),
        .req_wdata(req_wdata), .req_ready(req_ready), .done(done),
        .rd_data(rd_data), .bus_error_seen(bus_error_seen),
        .autovector_seen(autovector_seen), .addr(addr),
        .byte_count_code_high(byte_count_code_high),
        .byte_count_code_low(byte_count_code_low), .space_code(space_code),
        .read_write(read_write), .location_strobe_n(location_strobe_n),
        .payload_strobe_n(payload_strobe_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe),
        .port_ack_high_n(port_ack_high_n), .port_ack_low_n(port_ack_low_n),
        .bus_error_n(bus_error_n), .halt_n(halt_n),
        .autovector_n(autovector_n));

    far_memory u_far_memory (.clk(clk), .reset(reset), .addr(addr),
        .byte_count_code_high(byte_count_code_high),
        .byte_count_code_low(byte_count_code_low),
        .location_strobe_n(location_strobe_n),
        .payload_strobe_n(payload_strobe_n), .read_write(read_write),
        .data_out(data_out), .port8(port8), .waits(waits), .no_ack(no_ack),
        .err(err), .halt(halt), .autovector_input(autovector_input), .data_in(data_in),
        .port_ack_high_n(port_ack_high_n), .port_ack_low_n(port_ack_low_n),
        .bus_error_n(bus_error_n), .halt_n(halt_n),
        .autovector_n(autovector_n));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // bus monitor: per-cycle codes and strobe spacing in clk units
    always @(posedge clk)
    begin
        tcnt++;
        loc_p <= location_strobe_n;
        pay_p <= payload_strobe_n;
        oe_p  <= data_oe;
        rw_p  <= read_write;
        if (rw_p !== read_write)
            flips++;
        if (loc_p && !location_strobe_n)
        begin
            ncyc++;
            lt = tcnt;
            la = addr;
            lc = {byte_count_code_high, byte_count_code_low};
            if (ncyc == 1)
            begin
                fa = addr;
                fc = lc;
                fs = space_code;
            end
        end
        if (pay_p && !payload_strobe_n)
        begin
            pgap = tcnt - lt;
            wdat = data_out;
        end
        if (!oe_p && data_oe)
            dgap = tcnt - lt;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] bv(input int i);
        return 8'(i) ^ 8'h5a;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (exp !== got)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic op(input logic w, iack, input logic [19:0] a,
                      input logic [1:0] c, sp, input logic [31:0] wd);
        int n;
        @(posedge clk);
        ncyc = 0;
        req_valid <= 1'b1;
        req_write <= w;
        req_iack  <= iack;
        req_addr  <= a;
        req_count <= c;
        req_space <= sp;
        req_wdata <= wd;
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 100)
            chk("done", 1, 0);
    endtask

    task automatic set_far(input logic p8, na, e, h, av, input logic [3:0] wt);
        port8  <= p8;
        no_ack <= na;
        err    <= e;
        halt   <= h;
        autovector_input   <= av;
        waits  <= wt;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_long16();
        set_far(0, 0, 0, 0, 0, 4'h0);
        op(0, 0, 20'h80010, 2'h0, 2'h1, 32'h0);
        chk("rd_data", {bv(16), bv(17), bv(18), bv(19)}, rd_data);
        chk("cycles", 2, 32'(ncyc));
        chk("first code", 0, 32'(fc));
        chk("last code", 2, 32'(lc));
        chk("first addr", 24'hf80010, 32'(fa));
        chk("last addr", 24'hf80012, 32'(la));
        chk("read strobe gap", 0, 32'(pgap));
        chk("space", 3'h5, 32'(fs));
    endtask

    task automatic t_long8();
        set_far(1, 0, 0, 0, 0, 4'h2);
        op(0, 0, 20'h00020, 2'h0, 2'h2, 32'h0);
        chk("rd_data", {bv(32), bv(33), bv(34), bv(35)}, rd_data);
        chk("cycles", 4, 32'(ncyc));
        chk("last code", 1, 32'(lc));
        chk("last addr", 24'h000023, 32'(la));
        chk("space", 3'h6, 32'(fs));
    endtask

    // odd start: one byte first, then an aligned pair
    task automatic t_odd3();
        set_far(0, 0, 0, 0, 0, 4'h1);
        op(0, 0, 20'h00031, 2'h3, 2'h1, 32'h0);
        chk("rd_data", {8'h00, bv(49), bv(50), bv(51)}, rd_data);
        chk("cycles", 2, 32'(ncyc));
        chk("last code", 2, 32'(lc));
    endtask

    task automatic t_writes();
        set_far(1, 0, 0, 0, 0, 4'h0);
        op(1, 0, 20'h00040, 2'h2, 2'h1, 32'h0000abcd);
        chk("mem40", 8'hab, 32'(u_far_memory.mem[64]));
        chk("mem41", 8'hcd, 32'(u_far_memory.mem[65]));
        chk("write strobe gap", 2, 32'(pgap));
        chk("data gap", 1, 32'(dgap));
        set_far(0, 0, 0, 0, 0, 4'h0);
        flips = 0;
        op(1, 0, 20'h00045, 2'h1, 2'h1, 32'h000000ef);
        chk("mem45", 8'hef, 32'(u_far_memory.mem[69]));
        chk("mem44", bv(68), 32'(u_far_memory.mem[68]));
        chk("both lanes", 16'hefef, 32'(wdat));
        chk("rw flips", 0, 32'(flips));
        chk("read_write", 0, 32'(read_write));
    endtask

    task automatic t_bus_error_input();
        set_far(0, 1, 1, 1, 0, 4'h1);
        op(0, 0, 20'h00050, 2'h0, 2'h1, 32'h0);
        chk("bus_error_seen", 1, 32'(bus_error_seen));
        chk("cycles", 1, 32'(ncyc));
    endtask

    task automatic t_autovector_input();
        set_far(0, 1, 0, 0, 1, 4'h0);
        op(0, 1, 20'h00000, 2'h1, 2'h3, 32'h0);
        chk("autovector_seen", 1, 32'(autovector_seen));
        chk("bus_error_seen", 0, 32'(bus_error_seen));
        // still held low: an ordinary read must ignore it
        set_far(0, 0, 0, 0, 1, 4'h0);
        op(0, 0, 20'h00060, 2'h1, 2'h1, 32'h0);
        chk("autovector_seen", 0, 32'(autovector_seen));
        chk("rd_data", {24'h0, bv(96)}, rd_data);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        {req_valid, req_write, req_iack} = 3'h0;
        {req_addr, req_count, req_space, req_wdata} = '0;
        {port8, no_ack, err, halt, autovector_input} = 5'h00;
        waits = 4'h0;
        reset = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk("req_ready", 1, 32'(req_ready));
        chk("strobes", 2'h3, 32'({location_strobe_n, payload_strobe_n}));
        chk("data_oe", 0, 32'(data_oe));
        chk("space", 3'h5, 32'(space_code));
        t_long16();
        t_long8();
        t_odd3();
        t_writes();
        t_bus_error_input();
        t_autovector_input();
        tally_and_finish();
    end
endmodule
